// ===== pzt_pin_board.sv
// Board model for the port pins: resolves each pin from drivers and pull-ups.
// Assumes the bench supplies what external parts drive on undriven pins.
`timescale 1ns/1ps
module pzt_pin_board (
	input wire logic [7:0] p0_out,
	input wire logic [7:0] p0_oe,
	input wire logic [7:0] p0_pullup_en,
	input wire logic [7:0] p0_ext,
	input wire logic [7:0] p1_out,
	input wire logic [7:0] p1_oe,
	input wire logic [7:0] p1_pullup_en,
	input wire logic [7:0] p1_ext,
	input wire logic p2_5_out,
	input wire logic p2_5_oe,
	input wire logic [7:0] p2_pullup_en,
	input wire logic [7:0] p2_ext,
	output logic [7:0] p0_pin,
	output logic [7:0] p1_pin,
	output logic [7:0] p2_pin
);
	logic [7:0] p2_drv;
	// Device driver wins, then pull-up, then the external part
	assign p0_pin = (p0_oe & p0_out) | (~p0_oe & (p0_pullup_en | p0_ext));
	assign p1_pin = (p1_oe & p1_out) | (~p1_oe & (p1_pullup_en | p1_ext));
	assign p2_drv = p2_pullup_en | p2_ext;
	assign p2_pin = {p2_drv[7:6], p2_5_oe ? p2_5_out : p2_drv[5], p2_drv[4:0]};
endmodule // pzt_pin_board

// ===== pzt_pkg.sv
// Constants for the logic of ports 0, 1 and 2: APB offsets, fields, resets.
// Assumes a 32-bit APB with byte addresses on paddr[7:0].
package pzt_pkg;
	localparam logic [7:0] OFS_P0_LATCH = 8'h00;
	localparam logic [7:0] OFS_P0_DIR = 8'h04;
	localparam logic [7:0] OFS_P1_LATCH = 8'h08;
	localparam logic [7:0] OFS_P1_DIR = 8'h0c;
	localparam logic [7:0] OFS_PIN_READ = 8'h10;
	localparam logic [7:0] OFS_PULLUP = 8'h14;
	localparam logic [7:0] OFS_RT_CTRL = 8'h18;
	localparam logic [7:0] OFS_RT_BUF = 8'h1c;
	localparam logic [7:0] OFS_PWM_CTRL = 8'h20;
	localparam logic [7:0] OFS_P1_FSEL = 8'h24;
	localparam logic [7:0] OFS_CSER1_MODE = 8'h28;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h2c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
	localparam int RT_EN_BIT = 0;
	localparam int RT_BYTE_BIT = 1;
	localparam int RT_PIN_TRIG_BIT = 2;
	localparam int PWM_EN0_BIT = 0;
	localparam int PWM_EN1_BIT = 1;
	localparam int FSEL_CLK_BIT = 2;
	localparam int FSEL_RX_BIT = 3;
	localparam int FSEL_TX_BIT = 4;
	localparam int CSER1_CLK_OUT_BIT = 0;
	localparam int CSER1_EN_BIT = 7;
	localparam logic [7:0] P2_PULLUP_MASK = 8'hfc;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
endpackage

// ===== pzt_ports.sv
// Pin logic for ports 0, 1 and 2 with an APB register slave.
// Assumes pins synchronous to pclk and peripherals that use the routed levels.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pzt_ports (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic [7:0] p0_in,
	output logic [7:0] p0_out,
	output logic [7:0] p0_oe,
	output logic [7:0] p0_pullup_en,
	input wire logic [7:0] p1_in,
	output logic [7:0] p1_out,
	output logic [7:0] p1_oe,
	output logic [7:0] p1_pullup_en,
	input wire logic [7:0] p2_in,
	output logic p2_5_out,
	output logic p2_5_oe,
	output logic [7:0] p2_pullup_en,
	input wire logic rt_trig_low,
	input wire logic rt_trig_high,
	input wire logic pwm_channel_0_out,
	input wire logic pwm_channel_1_out,
	input wire logic serial2_clk_out,
	input wire logic serial2_clk_oe,
	input wire logic serial2_data_out,
	input wire logic serial1_clk_out,
	output logic uart2_baud_clock_in,
	output logic serial2_shift_clock,
	output logic serial2_data_in,
	output logic nmi_req,
	output logic [5:0] ext_irq,
	output logic timer1_capture_trig,
	output logic timer1_count_clock,
	output logic rt_pin_trigger,
	output logic timer2_capture_trig,
	output logic timer2_external_clock_in,
	output logic timer0_capture_trig,
	output logic timer0_count_clock,
	output logic uart_baud_clock_in,
	output logic serial1_shift_clock,
	output logic adc_start_trig,
	output logic serial0_data_in
);
	logic [7:0] p0_latch_ff;
	logic [7:0] port0_direction_reg_ff;
	logic [7:0] p1_latch_ff;
	logic [7:0] port1_direction_reg_ff;
	logic [23:0] pullup_ff;
	logic [7:0] realtime_output_control_ff;
	logic [7:0] realtime_buffer_low_ff;
	logic [7:0] realtime_buffer_high_ff;
	logic [7:0] rt_out_ff;
	logic [7:0] pulse_width_control_reg_ff;
	logic [7:0] port1_function_select_reg_ff;
	logic [7:0] clocked_serial1_mode_reg_ff;
	logic [7:0] irq_stat_ff;
	logic [7:0] irq_mask_ff;
	logic [7:0] p2_prev_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [7:0] nxt_irq_stat;
	logic [7:0] nxt_rt_out;

	wire wr_en = psel & penable & pwrite & ce;
	wire rd_cap = psel & ~penable & ce;
	wire w_p0l = wr_en & (paddr == pzt_pkg::OFS_P0_LATCH);
	wire w_p0d = wr_en & (paddr == pzt_pkg::OFS_P0_DIR);
	wire w_p1l = wr_en & (paddr == pzt_pkg::OFS_P1_LATCH);
	wire w_p1d = wr_en & (paddr == pzt_pkg::OFS_P1_DIR);
	wire w_pu = wr_en & (paddr == pzt_pkg::OFS_PULLUP);
	wire w_rtc = wr_en & (paddr == pzt_pkg::OFS_RT_CTRL);
	wire w_rtb = wr_en & (paddr == pzt_pkg::OFS_RT_BUF);
	wire w_pwm = wr_en & (paddr == pzt_pkg::OFS_PWM_CTRL);
	wire w_fsel = wr_en & (paddr == pzt_pkg::OFS_P1_FSEL);
	wire w_cs1 = wr_en & (paddr == pzt_pkg::OFS_CSER1_MODE);
	wire w_ist = wr_en & (paddr == pzt_pkg::OFS_IRQ_STAT);
	wire w_imk = wr_en & (paddr == pzt_pkg::OFS_IRQ_MASK);
	wire mapped = (paddr <= pzt_pkg::OFS_IRQ_MASK) & (paddr[1:0] == 2'b00);

	wire rt_en = realtime_output_control_ff[pzt_pkg::RT_EN_BIT];
	wire rt_byte = realtime_output_control_ff[pzt_pkg::RT_BYTE_BIT];
	wire p2_1_rise = p2_in[1] & ~p2_prev_ff[1];
	wire pin_trig = realtime_output_control_ff[pzt_pkg::RT_PIN_TRIG_BIT] & p2_1_rise;
	wire trig_lo = rt_trig_low | pin_trig;
	wire trig_hi = rt_byte ? trig_lo : rt_trig_high;
	wire en0 = pulse_width_control_reg_ff[pzt_pkg::PWM_EN0_BIT];
	wire en1 = pulse_width_control_reg_ff[pzt_pkg::PWM_EN1_BIT];
	wire port1_bit2_function_select = port1_function_select_reg_ff[pzt_pkg::FSEL_CLK_BIT];
	wire port1_bit3_function_select = port1_function_select_reg_ff[pzt_pkg::FSEL_RX_BIT];
	wire port1_bit4_function_select = port1_function_select_reg_ff[pzt_pkg::FSEL_TX_BIT];
	wire cs1_clk_drive = clocked_serial1_mode_reg_ff[pzt_pkg::CSER1_EN_BIT]
		& clocked_serial1_mode_reg_ff[pzt_pkg::CSER1_CLK_OUT_BIT];
	wire [7:0] p2_events = p2_in ^ p2_prev_ff;

	// Pin read word: live levels of all three ports
	wire [31:0] pin_word = {8'h00, p2_in, p1_in, p0_in};

	// Port 0: driver follows direction; source is latch or real-time data
	assign p0_oe = port0_direction_reg_ff;
	assign p0_out = rt_en ? rt_out_ff : p0_latch_ff;
	assign p0_pullup_en = pullup_ff[7:0];

	// Port 1: alternate functions take over bits 0-4
	assign p1_out[0] = en0 ? pwm_channel_0_out : p1_latch_ff[0];
	assign p1_oe[0] = en0 | port1_direction_reg_ff[0];
	assign p1_out[1] = en1 ? pwm_channel_1_out : p1_latch_ff[1];
	assign p1_oe[1] = en1 | port1_direction_reg_ff[1];
	assign p1_out[2] = port1_bit2_function_select ? serial2_clk_out : p1_latch_ff[2];
	assign p1_oe[2] = port1_bit2_function_select ? serial2_clk_oe
		: port1_direction_reg_ff[2];
	assign p1_out[3] = p1_latch_ff[3];
	assign p1_oe[3] = ~port1_bit3_function_select & port1_direction_reg_ff[3];
	assign p1_out[4] = port1_bit4_function_select ? serial2_data_out : p1_latch_ff[4];
	assign p1_oe[4] = port1_bit4_function_select | port1_direction_reg_ff[4];
	assign p1_out[7:5] = p1_latch_ff[7:5];
	assign p1_oe[7:5] = port1_direction_reg_ff[7:5];
	assign p1_pullup_en = pullup_ff[15:8];
	assign uart2_baud_clock_in = p1_in[2];
	assign serial2_shift_clock = p1_in[2];
	assign serial2_data_in = p1_in[3];

	// Port 2: input only, except the serial 1 clock on bit 5
	assign p2_5_out = serial1_clk_out;
	assign p2_5_oe = cs1_clk_drive;
	assign p2_pullup_en = pullup_ff[23:16] & pzt_pkg::P2_PULLUP_MASK;
	assign nmi_req = p2_in[0];
	assign ext_irq = p2_in[6:1];
	assign timer1_capture_trig = p2_in[1];
	assign timer1_count_clock = p2_in[1];
	assign rt_pin_trigger = p2_in[1];
	assign timer2_capture_trig = p2_in[2];
	assign timer2_external_clock_in = p2_in[3];
	assign timer0_capture_trig = p2_in[4];
	assign timer0_count_clock = p2_in[4];
	assign uart_baud_clock_in = p2_in[5];
	assign serial1_shift_clock = p2_in[5];
	assign adc_start_trig = p2_in[6];
	assign serial0_data_in = p2_in[7];

	// APB answer: one wait-free access phase while ce is high; pready waits while ce is low
	assign pready = penable & ce;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = rdata_ff;
	assign irq = |(irq_stat_ff & irq_mask_ff);

	always_comb
	begin
		case (paddr)
			pzt_pkg::OFS_P0_LATCH: nxt_rdata = {24'h000000, p0_latch_ff};
			pzt_pkg::OFS_P0_DIR: nxt_rdata = {24'h000000, port0_direction_reg_ff};
			pzt_pkg::OFS_P1_LATCH: nxt_rdata = {24'h000000, p1_latch_ff};
			pzt_pkg::OFS_P1_DIR: nxt_rdata = {24'h000000, port1_direction_reg_ff};
			pzt_pkg::OFS_PIN_READ: nxt_rdata = pin_word;
			pzt_pkg::OFS_PULLUP:
				nxt_rdata = {8'h00, pullup_ff[23:16] & pzt_pkg::P2_PULLUP_MASK, pullup_ff[15:0]};
			pzt_pkg::OFS_RT_CTRL: nxt_rdata = {24'h000000, realtime_output_control_ff};
			pzt_pkg::OFS_RT_BUF:
				nxt_rdata = {8'h00, rt_out_ff, realtime_buffer_high_ff, realtime_buffer_low_ff};
			pzt_pkg::OFS_PWM_CTRL: nxt_rdata = {24'h000000, pulse_width_control_reg_ff};
			pzt_pkg::OFS_P1_FSEL: nxt_rdata = {24'h000000, port1_function_select_reg_ff};
			pzt_pkg::OFS_CSER1_MODE: nxt_rdata = {24'h000000, clocked_serial1_mode_reg_ff};
			pzt_pkg::OFS_IRQ_STAT: nxt_rdata = {24'h000000, irq_stat_ff};
			pzt_pkg::OFS_IRQ_MASK: nxt_rdata = {24'h000000, irq_mask_ff};
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	// Pin change events win over a same-cycle write-one clear
	always_comb
	begin
		nxt_irq_stat = (irq_stat_ff & ~(w_ist ? pwdata[7:0] : 8'h00)) | p2_events;
	end

	// Real-time latch: low nibble, high nibble, or whole byte on one trigger
	always_comb
	begin
		nxt_rt_out = rt_out_ff;
		if (trig_lo)
			nxt_rt_out[3:0] = realtime_buffer_low_ff[3:0];
		if (trig_hi)
			nxt_rt_out[7:4] = rt_byte ? realtime_buffer_low_ff[7:4]
				: realtime_buffer_high_ff[3:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port0_direction_reg_ff <= pzt_pkg::RST_DIR;
			port1_direction_reg_ff <= pzt_pkg::RST_DIR;
			realtime_output_control_ff <= pzt_pkg::RST_CTRL;
			pulse_width_control_reg_ff <= pzt_pkg::RST_CTRL;
			port1_function_select_reg_ff <= pzt_pkg::RST_CTRL;
			clocked_serial1_mode_reg_ff <= pzt_pkg::RST_CTRL;
			pullup_ff <= 24'h000000;
			irq_mask_ff <= pzt_pkg::RST_CTRL;
		end
		else if (ce)
		begin
			if (w_p0d)
				port0_direction_reg_ff <= pwdata[7:0];
			if (w_p1d)
				port1_direction_reg_ff <= pwdata[7:0];
			if (w_rtc)
				realtime_output_control_ff <= pwdata[7:0];
			if (w_pwm)
				pulse_width_control_reg_ff <= pwdata[7:0];
			if (w_fsel)
				port1_function_select_reg_ff <= pwdata[7:0];
			if (w_cs1)
				clocked_serial1_mode_reg_ff <= pwdata[7:0];
			if (w_pu)
				pullup_ff <= pwdata[23:0];
			if (w_imk)
				irq_mask_ff <= pwdata[7:0];
		end
	end

	// Data latches: value after reset carries no meaning
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			p0_latch_ff <= pzt_pkg::RST_LATCH;
			p1_latch_ff <= pzt_pkg::RST_LATCH;
			realtime_buffer_low_ff <= pzt_pkg::RST_LATCH;
			realtime_buffer_high_ff <= pzt_pkg::RST_LATCH;
			rt_out_ff <= pzt_pkg::RST_LATCH;
		end
		else if (ce)
		begin
			if (w_p0l)
				p0_latch_ff <= pwdata[7:0];
			if (w_p1l)
				p1_latch_ff <= pwdata[7:0];
			if (w_rtb)
				realtime_buffer_low_ff <= pwdata[7:0];
			if (w_rtb)
				realtime_buffer_high_ff <= pwdata[15:8];
			rt_out_ff <= nxt_rt_out;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat_ff <= pzt_pkg::RST_CTRL;
			p2_prev_ff <= pzt_pkg::RST_CTRL;
			rdata_ff <= 32'h00000000;
		end
		else if (ce)
		begin
			irq_stat_ff <= nxt_irq_stat;
			p2_prev_ff <= p2_in;
			if (rd_cap)
				rdata_ff <= nxt_rdata;
		end
	end

	chk_reset_inputs: assert property (@(posedge pclk)
		$rose(presetn) |-> (p0_oe == 8'h00) && (p1_oe == 8'h00))
		else $error("port driver on right after reset");

	chk_p0_port_drive: assert property (@(posedge pclk) disable iff (!presetn)
		!rt_en |-> (p0_out == p0_latch_ff) && (p0_oe == port0_direction_reg_ff))
		else $error("port 0 not driven from latch");

	chk_rt_byte_load: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && rt_byte && trig_lo) |=> (rt_out_ff == $past(realtime_buffer_low_ff)))
		else $error("real-time byte load wrong");

	chk_rt_nibble_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !rt_byte && trig_lo && !trig_hi)
		|=> (rt_out_ff[7:4] == $past(rt_out_ff[7:4])))
		else $error("high nibble moved on low trigger");

	chk_rt_select: assert property (@(posedge pclk) disable iff (!presetn)
		rt_en |-> p0_out == rt_out_ff)
		else $error("real-time data not on port 0");

	chk_pwm_pin: assert property (@(posedge pclk) disable iff (!presetn)
		en0 |-> p1_oe[0] && (p1_out[0] == pwm_channel_0_out))
		else $error("PWM 0 not on port 1 bit 0");

	chk_rx_input: assert property (@(posedge pclk) disable iff (!presetn)
		port1_bit3_function_select |-> !p1_oe[3])
		else $error("receive pin driven");

	chk_tx_drive: assert property (@(posedge pclk) disable iff (!presetn)
		port1_bit4_function_select |-> p1_oe[4] && (p1_out[4] == serial2_data_out))
		else $error("transmit pin not driven by serial 2");

	chk_clk_pin_select: assert property (@(posedge pclk) disable iff (!presetn)
		port1_bit2_function_select
		|-> (p1_oe[2] == serial2_clk_oe) && (p1_out[2] == serial2_clk_out))
		else $error("serial 2 clock pin not handed over");

	chk_p1_low_port: assert property (@(posedge pclk) disable iff (!presetn)
		!en0 |-> (p1_oe[0] == port1_direction_reg_ff[0]) && (p1_out[0] == p1_latch_ff[0]))
		else $error("port 1 bit 0 not plain port");

	chk_p1_high_port: assert property (@(posedge pclk) disable iff (!presetn)
		p1_oe[7:5] == port1_direction_reg_ff[7:5])
		else $error("port 1 bits 5-7 not plain port");

	chk_p2_5_clock: assert property (@(posedge pclk) disable iff (!presetn)
		p2_5_oe |-> clocked_serial1_mode_reg_ff[pzt_pkg::CSER1_EN_BIT])
		else $error("serial 1 clock driven while disabled");

	chk_pull_p2_low: assert property (@(posedge pclk) disable iff (!presetn)
		p2_pullup_en[1:0] == 2'b00)
		else $error("pull-up on port 2 bit 0 or 1");

	chk_pin_read_live: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_cap && paddr == pzt_pkg::OFS_PIN_READ) |=> prdata[23:16] == $past(p2_in))
		else $error("port 2 read not live");

	chk_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && p2_events[0]) |=> irq_stat_ff[0])
		else $error("pin event lost");

	chk_event_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && (p2_events != 8'h00))
		|=> ((irq_stat_ff & $past(p2_events)) == $past(p2_events)))
		else $error("pin event lost to clear");

	chk_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
		!ce |=> $stable(rt_out_ff) && $stable(irq_stat_ff) && $stable(p0_latch_ff))
		else $error("state moved while clock enable low");

	chk_nmi_route: assert property (@(posedge pclk) disable iff (!presetn)
		nmi_req == p2_in[0])
		else $error("non-maskable request not passed");
endmodule // pzt_ports

// ===== pzt_ports_tb_top.sv
// Self-checking bench for the port logic, driven over APB.
// Assumes the board model resolves all pins fed back to the design.
`timescale 1ns/1ps
module pzt_ports_tb_top;
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr, p0_ext, p1_ext, p2_ext;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, irq, err, ce;
	logic [7:0] p0_in, p0_out, p0_oe, p0_pu, p1_in, p1_out, p1_oe, p1_pu, p2_in, p2_pu;
	logic p2_5_out, p2_5_oe, trl, trh, pw0, pw1, s2co, s2coe, s2do, s1co;
	logic u2b, s2sc, s2di, nmi, t1c, t1k, rtp, t2c, t2k, t0c, t0k, ub, s1sc, adc, s0di;
	logic [5:0] ext_irq;
	int errors, total_checks;
	pzt_ports pzt_ports_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .p0_in(p0_in), .p0_out(p0_out),
		.p0_oe(p0_oe), .p0_pullup_en(p0_pu), .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe),
		.p1_pullup_en(p1_pu), .p2_in(p2_in), .p2_5_out(p2_5_out), .p2_5_oe(p2_5_oe),
		.p2_pullup_en(p2_pu), .rt_trig_low(trl), .rt_trig_high(trh), .pwm_channel_0_out(pw0),
		.pwm_channel_1_out(pw1), .serial2_clk_out(s2co), .serial2_clk_oe(s2coe),
		.serial2_data_out(s2do), .serial1_clk_out(s1co), .uart2_baud_clock_in(u2b),
		.serial2_shift_clock(s2sc), .serial2_data_in(s2di), .nmi_req(nmi), .ext_irq(ext_irq),
		.timer1_capture_trig(t1c), .timer1_count_clock(t1k), .rt_pin_trigger(rtp),
		.timer2_capture_trig(t2c), .timer2_external_clock_in(t2k), .timer0_capture_trig(t0c),
		.timer0_count_clock(t0k), .uart_baud_clock_in(ub), .serial1_shift_clock(s1sc),
		.adc_start_trig(adc), .serial0_data_in(s0di));
	pzt_pin_board pzt_pin_board_i (.p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup_en(p0_pu),
		.p0_ext(p0_ext), .p1_out(p1_out), .p1_oe(p1_oe), .p1_pullup_en(p1_pu),
		.p1_ext(p1_ext), .p2_5_out(p2_5_out), .p2_5_oe(p2_5_oe), .p2_pullup_en(p2_pu),
		.p2_ext(p2_ext), .p0_pin(p0_in), .p1_pin(p1_in), .p2_pin(p2_in));
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer, then one idle edge so outputs settle before sampling
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			errors++;
			close_out();
		end
		else
		begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task automatic pulse(logic hi);
		@(posedge pclk);
		if (hi) trh <= 1'b1; else trl <= 1'b1;
		@(posedge pclk);
		trh <= 1'b0;
		trl <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, trl, trh, pw0, pw1, s2co, s2coe, s2do, s1co} = '0;
		paddr = 8'h00;
		ce = 1'b1;
		pwdata = 32'h0;
		{p0_ext, p1_ext, p2_ext} = '0;
		errors = 0;
		total_checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("oe after reset", {p2_5_oe, p1_oe, p0_oe}, 32'h0);
		chk("pullups after reset", {p2_pu, p1_pu, p0_pu}, 32'h0);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge pclk) p2_ext <= 8'h01 << k;
			repeat (2) @(posedge pclk);
			chk("p2 routing", {nmi, ext_irq, t1c, t1k, rtp, t2c, t2k, t0c, t0k, ub, s1sc, adc, s0di},
				{p2_in[0], p2_in[6:1], {3{p2_in[1]}}, p2_in[2], p2_in[3], {2{p2_in[4]}},
				{2{p2_in[5]}}, p2_in[6], p2_in[7]});
			chk("p2 bit set", {31'h0, p2_in[k]}, 32'h1);
			apb(1'b0, pzt_pkg::OFS_PIN_READ, 32'h0);
			chk("p2 pin read", rd, {8'h00, 8'h01 << k, p1_in, p0_in});
		end
		p2_ext <= 8'h00;
		apb(1'b1, pzt_pkg::OFS_IRQ_STAT, 32'hff);
		p2_ext <= 8'h08;
		apb(1'b0, pzt_pkg::OFS_IRQ_STAT, 32'h0);
		chk("irq status", rd, 32'h08);
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, pzt_pkg::OFS_IRQ_MASK, 32'h08);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		apb(1'b1, pzt_pkg::OFS_IRQ_STAT, 32'h08);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		p0_ext <= 8'h30;
		apb(1'b1, pzt_pkg::OFS_P0_DIR, 32'h0f);
		apb(1'b1, pzt_pkg::OFS_P0_LATCH, 32'ha5);
		chk("p0 oe", p0_oe, 32'h0f);
		apb(1'b0, pzt_pkg::OFS_PIN_READ, 32'h0);
		chk("p0 pins", rd[7:0], 32'h35);
		// Nibble mode, then byte mode where the high trigger is ignored
		apb(1'b1, pzt_pkg::OFS_RT_BUF, 32'ha53c);
		apb(1'b1, pzt_pkg::OFS_RT_CTRL, 32'h1);
		pulse(1'b0);
		chk("rt low nibble", p0_out, 32'h0c);
		pulse(1'b1);
		chk("rt high nibble", p0_out, 32'h5c);
		apb(1'b1, pzt_pkg::OFS_RT_CTRL, 32'h3);
		pulse(1'b1);
		chk("rt byte hold", p0_out, 32'h5c);
		pulse(1'b0);
		apb(1'b0, pzt_pkg::OFS_RT_BUF, 32'h0);
		chk("rt byte load", rd, 32'h3ca53c);
		chk("rt byte pins", p0_out, 32'h3c);
		// Clock enable low: a low trigger must not load the new buffer
		apb(1'b1, pzt_pkg::OFS_RT_BUF, 32'h0077);
		ce <= 1'b0;
		pulse(1'b0);
		chk("ce freeze", p0_out, 32'h3c);
		ce <= 1'b1;
		// Pin trigger: rising edge on port 2 bit 1 loads the byte
		apb(1'b1, pzt_pkg::OFS_RT_CTRL, 32'h7);
		p2_ext <= 8'h0a;
		repeat (3) @(posedge pclk);
		chk("rt pin trigger", p0_out, 32'h77);
		pw0 <= 1'b1;
		apb(1'b1, pzt_pkg::OFS_PWM_CTRL, 32'h3);
		chk("pwm oe", p1_oe[1:0], 32'h3);
		chk("pwm out", p1_out[1:0], 32'h1);
		apb(1'b1, pzt_pkg::OFS_PWM_CTRL, 32'h0);
		apb(1'b1, pzt_pkg::OFS_P1_DIR, 32'he1);
		apb(1'b1, pzt_pkg::OFS_P1_LATCH, 32'ha0);
		chk("p1 port oe", p1_oe, 32'he1);
		chk("p1 port out", {p1_out[7:5], p1_out[0]}, 32'ha);
		{s2co, s2coe, s2do} <= 3'b110;
		p1_ext <= 8'h08;
		apb(1'b1, pzt_pkg::OFS_P1_FSEL, 32'h1c);
		chk("fsel oe", p1_oe[4:2], 32'h5);
		chk("fsel out", {p1_out[4], p1_out[2]}, 32'h1);
		chk("serial2 in", {u2b, s2sc, s2di}, 32'h7);
		s1co <= 1'b1;
		apb(1'b1, pzt_pkg::OFS_CSER1_MODE, 32'h81);
		chk("p25 drive", {p2_5_oe, p2_5_out, s1sc}, 32'h7);
		apb(1'b1, pzt_pkg::OFS_CSER1_MODE, 32'h80);
		chk("p25 input", {31'h0, p2_5_oe}, 32'h0);
		apb(1'b1, pzt_pkg::OFS_PULLUP, 32'hffffffff);
		apb(1'b0, pzt_pkg::OFS_PULLUP, 32'h0);
		chk("pullup read", rd, 32'hfcffff);
		chk("p2 pullups", p2_pu, 32'hfc);
		chk("p0 p1 pullups", {p1_pu, p0_pu}, 32'hffff);
		apb(1'b0, 8'h34, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		close_out();
	end
endmodule // pzt_ports_tb_top
